// ### src/pin_level_readback_pin_function_mux.sv
// Eight-pin port with APB registers and per-pin function multiplexing.
//
// Notes on behaviour
// R1 - Readback bit: latch if output, else pin
// R2 - Readback is read-only; writes change nothing
// R3 - Pin 7 general I/O unless timer drives
// R4 - Pin 7 output compare in normal mode
// R5 - Pin 7 PWM mode 2 unless cleared by B
// R6 - Pin 7 feeds channel B capture
// R7 - Pin 7 is A/D trigger when both selects set
// R8 - Pin 6 general I/O unless timer drives
// R9 - Pin 6 output compare or PWM mode 1
// R10 - Pin 6 PWM mode 2 unless cleared by A
// R11 - Pin 6 feeds channel A capture
// R12 - PWM mode 1 suppresses channel B output
// R13 - Pin 5 PWM-DAC B when enabled
// R14 - Pin 4 PWM-DAC A when enabled
// R15 - Pin 3: I2C data, UART rx, else I/O
// R16 - Pin 2: I2C clock, UART tx, else I/O
// R17 - Pin 1: I2C data, UART rx, else I/O
// R18 - Pin 0: I2C clock, UART tx, else I/O
// R19 - Direction bits write-only, reset to zero
// R20 - Output latch read/write, resets to zero
// R21 - Pin levels pass two-stage synchroniser
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pin_level_readback_pin_function_mux (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pin_level_readback_pkg::PORT_W-1:0] pin_in,
  output logic [pin_level_readback_pkg::PORT_W-1:0] pin_out,
  output logic [pin_level_readback_pkg::PORT_W-1:0] pin_oe_n,
  input wire logic timer_chan_a_signal,
  input wire logic timer_chan_b_signal,
  input wire logic pwm_a_pin,
  input wire logic pwm_b_pin,
  input wire logic uart0_tx_pin,
  input wire logic uart1_tx_pin,
  input wire logic i2c0_scl_drive,
  input wire logic i2c0_sda_drive,
  input wire logic i2c1_scl_drive,
  input wire logic i2c1_sda_drive,
  output logic timer_a_capture,
  output logic timer_b_capture,
  output logic adc_ext_trigger,
  output logic uart0_rx_pin,
  output logic uart1_rx_pin,
  output logic i2c0_scl_in,
  output logic i2c0_sda_in,
  output logic i2c1_scl_in,
  output logic i2c1_sda_in
);
  import pin_level_readback_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [PORT_W-1:0] direction_bits; // 1 = general output
  logic [PORT_W-1:0] output_latch; // General output data
  logic [1:0] pin_route_ctrl; // Timer route selects
  logic [3:0] timer_mode_field; // Timer channel mode
  logic [3:0] chan_a_io_field; // Channel A I/O setup
  logic [3:0] chan_b_io_field; // Channel B I/O setup
  logic [2:0] counter_clear_src; // Counter clear source
  logic [9:0] periph_en; // Peripheral enable bits
  logic [PORT_W-1:0] pin_meta; // Synchroniser first stage
  logic [PORT_W-1:0] pin_sync; // Synchroniser second stage

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr; // Low address bits
  logic setup_phase; // First cycle of a transfer
  logic wr_fire; // Write commits this edge
  logic addr_hit; // Address maps a register
  logic [31:0] rd_word; // Read mux result
  logic [PORT_W-1:0] readback; // Pin level readback value

  assign addr = paddr[ADDR_W-1:0];
  assign setup_phase = psel & ~penable;
  // Unmapped or high addresses must not alias onto a register through the low byte
  assign wr_fire = psel & penable & pready & pwrite & addr_hit;

  // Decode also rejects unaligned or out-of-window addresses
  always_comb begin
    addr_hit = 1'b0;
    if (paddr[31:ADDR_W] == '0) begin
      unique case (addr)
        OFS_DIRECTION_BITS, OFS_OUTPUT_LATCH, OFS_PIN_LEVEL_READBACK,
        OFS_PIN_ROUTE_CTRL, OFS_TIMER_CFG, OFS_PERIPH_EN: addr_hit = 1'b1;
        default: addr_hit = 1'b0;
      endcase
    end
  end

  // Readback mixes latch and synchronised pin per direction bit
  assign readback = (direction_bits & output_latch) | (~direction_bits & pin_sync); // R1

  // Read mux; direction bits read as zero since their value is undefined
  always_comb begin
    rd_word = WORD_ZERO;
    unique case (addr)
      OFS_DIRECTION_BITS: rd_word = WORD_ZERO; // R19
      OFS_OUTPUT_LATCH: rd_word = {24'h00_0000, output_latch}; // R20
      OFS_PIN_LEVEL_READBACK: rd_word = {24'h00_0000, readback}; // R1
      OFS_PIN_ROUTE_CTRL: rd_word = {30'h0000_0000, pin_route_ctrl};
      OFS_TIMER_CFG: rd_word = {17'h0_0000, counter_clear_src, chan_b_io_field,
                                chan_a_io_field, timer_mode_field};
      OFS_PERIPH_EN: rd_word = {22'h00_0000, periph_en};
      default: rd_word = WORD_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // Answer is prepared in setup so all bus outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= WORD_ZERO;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase & ~addr_hit;
      // Data only on a mapped read; otherwise bus reads zero
      if (setup_phase && !pwrite && addr_hit) begin
        prdata <= rd_word;
      end else begin
        prdata <= WORD_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------
  // Direction bits, byte lane 0 only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direction_bits <= PORT_RST; // R19
    end else if (wr_fire && addr == OFS_DIRECTION_BITS && pstrb[0]) begin
      direction_bits <= pwdata[PORT_W-1:0]; // R19
    end
  end

  // Output latch, byte lane 0 only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_latch <= PORT_RST; // R20
    end else if (wr_fire && addr == OFS_OUTPUT_LATCH && pstrb[0]) begin
      output_latch <= pwdata[PORT_W-1:0]; // R20
    end
  end
  // Readback has no write path at all, so a write there is a no-op R2

  // Route selects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_route_ctrl <= 2'h0;
    end else if (wr_fire && addr == OFS_PIN_ROUTE_CTRL && pstrb[0]) begin
      pin_route_ctrl <= pwdata[1:0] & RT_MASK[1:0];
    end
  end

  // Timer channel settings, split over two byte lanes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_field <= 4'h0;
      chan_a_io_field <= 4'h0;
      chan_b_io_field <= 4'h0;
      counter_clear_src <= 3'h0;
    end else if (wr_fire && addr == OFS_TIMER_CFG) begin
      if (pstrb[0]) begin
        timer_mode_field <= pwdata[TM_MODE_LSB +: 4];
        chan_a_io_field <= pwdata[TM_IOA_LSB +: 4];
      end
      if (pstrb[1]) begin
        chan_b_io_field <= pwdata[TM_IOB_LSB +: 4];
        counter_clear_src <= pwdata[TM_CCLR_LSB +: 3];
      end
    end
  end

  // Peripheral enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_en <= 10'h000;
    end else if (wr_fire && addr == OFS_PERIPH_EN) begin
      if (pstrb[0]) begin
        periph_en[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        periph_en[9:8] <= pwdata[9:8] & PE_MASK[9:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // Only pin_sync is read; pin_meta may be metastable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= PORT_RST;
      pin_sync <= PORT_RST;
    end else begin
      pin_meta <= pin_in; // R21
      pin_sync <= pin_meta; // R21
    end
  end

  // ----------------------------------------------------------------
  // Timer decode
  // ----------------------------------------------------------------
  logic oc_a; // Channel A output compare
  logic oc_b; // Channel B output compare
  logic pwm1_a; // Channel A PWM mode 1
  logic pwm2_a; // Channel A PWM mode 2
  logic pwm2_b; // Channel B PWM mode 2
  logic tmr_a_drive; // Timer owns pin 6
  logic tmr_b_drive; // Timer owns pin 7
  logic cap_a_sel; // Pin 6 is capture input
  logic cap_b_sel; // Pin 7 is capture input

  // Compare output for io fields 0001-0011 and 0101-0111
  assign oc_a = timer_mode_field == MODE_NORMAL && !chan_a_io_field[3]
                && chan_a_io_field[1:0] != IO_LO_OFF; // R9
  assign oc_b = timer_mode_field == MODE_NORMAL && !chan_b_io_field[3]
                && chan_b_io_field[1:0] != IO_LO_OFF; // R4
  assign pwm1_a = timer_mode_field == MODE_PWM1 && chan_a_io_field[1:0] != IO_LO_OFF; // R9
  assign pwm2_a = timer_mode_field == MODE_PWM2 && chan_a_io_field[1:0] != IO_LO_OFF
                  && counter_clear_src != CCLR_BY_A; // R10
  assign pwm2_b = timer_mode_field == MODE_PWM2 && chan_b_io_field[1:0] != IO_LO_OFF
                  && counter_clear_src != CCLR_BY_B; // R5
  // Channel B has no PWM mode 1 term, so that mode never drives pin 7
  assign tmr_a_drive = pin_route_ctrl[RT_A_BIT] & (oc_a | pwm1_a | pwm2_a); // R9
  assign tmr_b_drive = pin_route_ctrl[RT_B_BIT] & (oc_b | pwm2_b); // R12
  assign cap_a_sel = pin_route_ctrl[RT_A_BIT] && timer_mode_field == MODE_NORMAL
                     && chan_a_io_field[3:2] == IO_HI_CAPTURE; // R11
  assign cap_b_sel = pin_route_ctrl[RT_B_BIT] && timer_mode_field == MODE_NORMAL
                     && chan_b_io_field[3:2] == IO_HI_CAPTURE; // R6

  // ----------------------------------------------------------------
  // Pin drive selection
  // ----------------------------------------------------------------
  logic [PORT_W-1:0] next_pin_out; // Drive value
  logic [PORT_W-1:0] next_pin_oe_n; // Low = driving

  // General I/O default, then alternate functions override by priority
  always_comb begin
    next_pin_out = output_latch; // R19
    next_pin_oe_n = ~direction_bits; // R19
    // Pin 7: timer drive, else general I/O
    if (tmr_b_drive) begin
      next_pin_out[PIN_TMR_B] = timer_chan_b_signal; // R4 R5
      next_pin_oe_n[PIN_TMR_B] = 1'b0;
    end // else general I/O R3
    // Pin 6: timer drive, else general I/O
    if (tmr_a_drive) begin
      next_pin_out[PIN_TMR_A] = timer_chan_a_signal; // R9 R10
      next_pin_oe_n[PIN_TMR_A] = 1'b0;
    end // else general I/O R8
    // Pin 5: PWM-DAC B
    if (periph_en[PE_PWM_B_BIT]) begin
      next_pin_out[PIN_PWM_B] = pwm_b_pin; // R13
      next_pin_oe_n[PIN_PWM_B] = 1'b0;
    end
    // Pin 4: PWM-DAC A
    if (periph_en[PE_PWM_A_BIT]) begin
      next_pin_out[PIN_PWM_A] = pwm_a_pin; // R14
      next_pin_oe_n[PIN_PWM_A] = 1'b0;
    end
    // Pin 3: open-drain data only pulls low; receive is input only
    if (periph_en[PE_I2C1_BIT]) begin
      next_pin_out[PIN_SDA1] = 1'b0; // R15
      next_pin_oe_n[PIN_SDA1] = i2c1_sda_drive;
    end else if (periph_en[PE_U1_RX_BIT]) begin
      next_pin_out[PIN_SDA1] = 1'b0; // R15
      next_pin_oe_n[PIN_SDA1] = 1'b1;
    end
    // Pin 2: open-drain clock, else push-pull transmit
    if (periph_en[PE_I2C1_BIT]) begin
      next_pin_out[PIN_SCL1] = 1'b0; // R16
      next_pin_oe_n[PIN_SCL1] = i2c1_scl_drive;
    end else if (periph_en[PE_U1_TX_BIT]) begin
      next_pin_out[PIN_SCL1] = uart1_tx_pin; // R16
      next_pin_oe_n[PIN_SCL1] = 1'b0;
    end
    // Pin 1: open-drain data, else receive input
    if (periph_en[PE_I2C0_BIT]) begin
      next_pin_out[PIN_SDA0] = 1'b0; // R17
      next_pin_oe_n[PIN_SDA0] = i2c0_sda_drive;
    end else if (periph_en[PE_U0_RX_BIT]) begin
      next_pin_out[PIN_SDA0] = 1'b0; // R17
      next_pin_oe_n[PIN_SDA0] = 1'b1;
    end
    // Pin 0: open-drain clock, else push-pull transmit
    if (periph_en[PE_I2C0_BIT]) begin
      next_pin_out[PIN_SCL0] = 1'b0; // R18
      next_pin_oe_n[PIN_SCL0] = i2c0_scl_drive;
    end else if (periph_en[PE_U0_TX_BIT]) begin
      next_pin_out[PIN_SCL0] = uart0_tx_pin; // R18
      next_pin_oe_n[PIN_SCL0] = 1'b0;
    end
  end

  // Registered pin drive; one cycle of latency buys glitch-free outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= PORT_RST;
      pin_oe_n <= ~PORT_RST; // All pins input after reset
    end else begin
      pin_out <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // Inputs to peripherals
  // ----------------------------------------------------------------
  // Unselected inputs park at their idle level: low for capture, high for serial
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_a_capture <= 1'b0;
      timer_b_capture <= 1'b0;
      adc_ext_trigger <= 1'b0;
      uart0_rx_pin <= 1'b1;
      uart1_rx_pin <= 1'b1;
      i2c0_scl_in <= 1'b1;
      i2c0_sda_in <= 1'b1;
      i2c1_scl_in <= 1'b1;
      i2c1_sda_in <= 1'b1;
    end else begin
      timer_a_capture <= cap_a_sel & pin_sync[PIN_TMR_A]; // R11
      timer_b_capture <= cap_b_sel & pin_sync[PIN_TMR_B]; // R6
      // Trigger input runs alongside whatever else pin 7 does
      adc_ext_trigger <= periph_en[PE_TRG_HI_BIT] & periph_en[PE_TRG_LO_BIT]
                         & pin_sync[PIN_TMR_B]; // R7
      uart0_rx_pin <= (periph_en[PE_I2C0_BIT] | ~periph_en[PE_U0_RX_BIT])
                      | pin_sync[PIN_SDA0]; // R17
      uart1_rx_pin <= (periph_en[PE_I2C1_BIT] | ~periph_en[PE_U1_RX_BIT])
                      | pin_sync[PIN_SDA1]; // R15
      i2c0_scl_in <= ~periph_en[PE_I2C0_BIT] | pin_sync[PIN_SCL0]; // R18
      i2c0_sda_in <= ~periph_en[PE_I2C0_BIT] | pin_sync[PIN_SDA0]; // R17
      i2c1_scl_in <= ~periph_en[PE_I2C1_BIT] | pin_sync[PIN_SCL1]; // R16
      i2c1_sda_in <= ~periph_en[PE_I2C1_BIT] | pin_sync[PIN_SDA1]; // R15
    end
  end

endmodule

`default_nettype wire

// ### src/pin_level_readback_pkg.sv
// Register map, field layout and encodings for the eight-pin port multiplexer.
package pin_level_readback_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DIRECTION_BITS = 8'h00; // Write-only direction
  localparam logic [7:0] OFS_OUTPUT_LATCH = 8'h04; // Output data
  localparam logic [7:0] OFS_PIN_LEVEL_READBACK = 8'h08; // Read-only pin view
  localparam logic [7:0] OFS_PIN_ROUTE_CTRL = 8'h0C; // Timer route selects
  localparam logic [7:0] OFS_TIMER_CFG = 8'h10; // Timer channel settings
  localparam logic [7:0] OFS_PERIPH_EN = 8'h14; // Peripheral enables

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int PORT_W = 8; // Pins in the port
  localparam int ADDR_W = 8; // Decoded address bits
  localparam logic [7:0] PORT_RST = 8'h00; // Direction and latch reset
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000; // Idle read data

  // ----------------------------------------------------------------
  // Pin numbers
  // ----------------------------------------------------------------
  localparam int PIN_TMR_B = 7; // Timer B, A/D trigger
  localparam int PIN_TMR_A = 6; // Timer A
  localparam int PIN_PWM_B = 5; // PWM-DAC channel B
  localparam int PIN_PWM_A = 4; // PWM-DAC channel A
  localparam int PIN_SDA1 = 3; // Second I2C data / second UART rx
  localparam int PIN_SCL1 = 2; // Second I2C clock / second UART tx
  localparam int PIN_SDA0 = 1; // First I2C data / first UART rx
  localparam int PIN_SCL0 = 0; // First I2C clock / first UART tx

  // ----------------------------------------------------------------
  // Route control fields
  // ----------------------------------------------------------------
  localparam int RT_A_BIT = 0; // timer_a_route_sel
  localparam int RT_B_BIT = 1; // timer_b_route_sel
  localparam logic [31:0] RT_MASK = 32'h0000_0003;

  // ----------------------------------------------------------------
  // Timer configuration fields
  // ----------------------------------------------------------------
  localparam int TM_MODE_LSB = 0; // timer_mode_field [3:0]
  localparam int TM_IOA_LSB = 4; // chan_a_io_field [7:4]
  localparam int TM_IOB_LSB = 8; // chan_b_io_field [11:8]
  localparam int TM_CCLR_LSB = 12; // counter_clear_src [14:12]
  localparam logic [31:0] TM_MASK = 32'h0000_7FFF;
  localparam logic [3:0] MODE_NORMAL = 4'h0; // Output compare / capture
  localparam logic [3:0] MODE_PWM1 = 4'h2; // PWM mode 1
  localparam logic [3:0] MODE_PWM2 = 4'h3; // PWM mode 2
  localparam logic [1:0] IO_LO_OFF = 2'h0; // Low field xx00: no output
  localparam logic [1:0] IO_HI_CAPTURE = 2'h2; // High field 10xx: capture
  localparam logic [2:0] CCLR_BY_A = 3'h1; // Cleared by channel A
  localparam logic [2:0] CCLR_BY_B = 3'h2; // Cleared by channel B

  // ----------------------------------------------------------------
  // Peripheral enable fields
  // ----------------------------------------------------------------
  localparam int PE_TRG_LO_BIT = 0; // trigger_select_lo
  localparam int PE_TRG_HI_BIT = 1; // trigger_select_hi
  localparam int PE_PWM_A_BIT = 2; // pwm_a_out_en
  localparam int PE_PWM_B_BIT = 3; // pwm_b_out_en
  localparam int PE_U0_RX_BIT = 4; // first_uart rx_enable
  localparam int PE_U0_TX_BIT = 5; // first_uart tx_enable
  localparam int PE_U1_RX_BIT = 6; // second_uart rx_enable
  localparam int PE_U1_TX_BIT = 7; // second_uart tx_enable
  localparam int PE_I2C0_BIT = 8; // first_i2c_unit i2c_enable
  localparam int PE_I2C1_BIT = 9; // second_i2c_unit i2c_enable
  localparam logic [31:0] PE_MASK = 32'h0000_03FF;

endpackage

// ### tb/pin_level_readback_monitor.sv
// Concurrent checks on the port multiplexer's bus and pin ports.
`timescale 1ns/1ps
`default_nettype none
module pin_level_readback_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] pin_in,
  input wire logic timer_a_capture,
  input wire logic timer_b_capture,
  input wire logic adc_ext_trigger,
  input wire logic uart0_rx_pin
);
  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  chk_high_addr_err: assert property (psel && !penable && paddr[31:8] != 24'h00_0000
    |=> pslverr && prdata == 32'h0000_0000) else $error("high address accepted");
  chk_readback_write_ok: assert property (psel && !penable && pwrite && paddr == 32'h0000_0008
    |=> pready && !pslverr) else $error("readback write refused");
  // ----------------------------------------------------------------
  // Pin inputs reach peripherals three edges late; a high needs a high pin, a receive low a low pin
  // ----------------------------------------------------------------
  chk_cap_a_source: assert property (timer_a_capture |-> $past(pin_in[6], 3))
    else $error("capture A without pin");
  chk_cap_b_source: assert property (timer_b_capture |-> $past(pin_in[7], 3))
    else $error("capture B without pin");
  chk_trig_source: assert property (adc_ext_trigger |-> $past(pin_in[7], 3))
    else $error("trigger without pin");
  chk_rx_low_source: assert property (!uart0_rx_pin |-> !$past(pin_in[1], 3))
    else $error("receive low without pin");
  cover property (psel && penable && pready && pwrite);
  cover property (pslverr);
  cover property (timer_a_capture && adc_ext_trigger);
endmodule
bind pin_level_readback_pin_function_mux pin_level_readback_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin_in(pin_in), .timer_a_capture(timer_a_capture),
  .timer_b_capture(timer_b_capture), .adc_ext_trigger(adc_ext_trigger), .uart0_rx_pin(uart0_rx_pin));
`default_nettype wire

// ### tb/pin_board_model.sv
// Board side of the eight pins: external drivers plus pull-ups.
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] ext_lvl,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  // Device drive wins; undriven lines float high on the pull-up
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_lvl) | (pin_oe_n & ~ext_en);
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the port multiplexer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import pin_level_readback_pkg::*;
  typedef struct packed {logic [1:0] rt; logic [14:0] tc; logic [9:0] pe; logic [7:0] out; logic [7:0] oe;} row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ee;
  logic [31:0] paddr, pwdata, prdata, rr;
  logic [3:0] pstrb;
  logic [7:0] pin_in, pin_out, pin_oe_n, ext_lvl, ext_en;
  logic [9:0] per; // Peripheral levels, released I2C drives
  logic cap_a, cap_b, trig, rx0, rx1, scl0, sda0, scl1, sda1;
  int error_cnt, check_count, cyc;
  // Direction all out, latch 0: peripheral-driven pins show 1, I2C and UART receive pins show released
  row_t rows [14] = '{
    '{2'h0, 15'h0000, 10'h000, 8'h00, 8'h00},
    '{2'h3, 15'h0510, 10'h000, 8'hC0, 8'h00},
    '{2'h3, 15'h0370, 10'h000, 8'hC0, 8'h00},
    '{2'h3, 15'h0480, 10'h000, 8'h00, 8'h00},
    '{2'h3, 15'h0112, 10'h000, 8'h40, 8'h00},
    '{2'h3, 15'h0113, 10'h000, 8'hC0, 8'h00},
    '{2'h3, 15'h1113, 10'h000, 8'h80, 8'h00},
    '{2'h3, 15'h2113, 10'h000, 8'h40, 8'h00},
    '{2'h3, 15'h0443, 10'h000, 8'h00, 8'h00},
    '{2'h1, 15'h0110, 10'h000, 8'h40, 8'h00},
    '{2'h0, 15'h0000, 10'h00C, 8'h30, 8'h00},
    '{2'h0, 15'h0000, 10'h0A0, 8'h05, 8'h00},
    '{2'h0, 15'h0000, 10'h050, 8'h00, 8'h0A},
    '{2'h0, 15'h0000, 10'h3F0, 8'h00, 8'h0F}};
  pin_level_readback_pin_function_mux i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .timer_chan_a_signal(per[0]), .timer_chan_b_signal(per[1]), .pwm_a_pin(per[2]), .pwm_b_pin(per[3]),
    .uart0_tx_pin(per[4]), .uart1_tx_pin(per[5]), .i2c0_scl_drive(per[6]), .i2c0_sda_drive(per[7]),
    .i2c1_scl_drive(per[8]), .i2c1_sda_drive(per[9]), .timer_a_capture(cap_a), .timer_b_capture(cap_b),
    .adc_ext_trigger(trig), .uart0_rx_pin(rx0), .uart1_rx_pin(rx1), .i2c0_scl_in(scl0),
    .i2c0_sda_in(sda0), .i2c1_scl_in(scl1), .i2c1_sda_in(sda1));
  pin_board_model i_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_lvl(ext_lvl), .ext_en(ext_en),
    .pin_in(pin_in));
  // ----------------------------------------------------------------
  // Bus tasks: hold the request until ready is sampled high
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready sampled high ends this wait; only the bench timeout ends it if ready never comes
    do @(posedge pclk); while (pready !== 1'b1);
    rr = prdata;
    ee = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // Idle edge so the next call never reassigns psel in this time step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, {24'h00_0000, a}, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, {24'h00_0000, a}, 32'h0000_0000);
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always #20 pclk = ~pclk;
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pstrb = 4'hF; per = 10'h3FF; ext_lvl = 8'h00; ext_en = 8'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(pin_oe_n, 8'hFF)
    `CHK(pin_out, 8'h00)
    @(posedge pclk);
    rd(OFS_OUTPUT_LATCH); `CHK(rr, 32'h0000_0000)
    wr(OFS_DIRECTION_BITS, 32'h0000_00FF); rd(OFS_DIRECTION_BITS); `CHK(rr, 32'h0000_0000)
    $display("test reset done");
    foreach (rows[i]) begin
      wr(OFS_PIN_ROUTE_CTRL, {30'h0, rows[i].rt}); wr(OFS_TIMER_CFG, {17'h0, rows[i].tc});
      wr(OFS_PERIPH_EN, {22'h0, rows[i].pe});
      repeat (2) @(posedge pclk);
      `CHK(pin_out, rows[i].out)
      `CHK(pin_oe_n, rows[i].oe)
    end
    // Last row has both I2C units on: pulling the drives low must enable the pins
    per <= 10'h000;
    repeat (2) @(posedge pclk);
    `CHK(pin_oe_n, 8'h00)
    `CHK(pin_out, 8'h00)
    per <= 10'h3FF;
    $display("test table done");
    // Low nibble output from latch, high nibble from the board
    wr(OFS_PIN_ROUTE_CTRL, 0); wr(OFS_TIMER_CFG, 0); wr(OFS_PERIPH_EN, 0);
    wr(OFS_DIRECTION_BITS, 32'h0000_000F); wr(OFS_OUTPUT_LATCH, 32'h0000_00A5);
    ext_en <= 8'hF0; ext_lvl <= 8'h6C;
    repeat (6) @(posedge pclk);
    rd(OFS_PIN_LEVEL_READBACK); `CHK(rr, 32'h0000_0065)
    rd(OFS_OUTPUT_LATCH); `CHK(rr, 32'h0000_00A5)
    wr(OFS_PIN_LEVEL_READBACK, 32'h0000_00FF); `CHK(ee, 1'b0)
    rd(OFS_PIN_LEVEL_READBACK); `CHK(rr, 32'h0000_0065)
    `CHK(pin_out[3:0], 4'h5)
    rd(8'h18); `CHK(ee, 1'b1)
    apb(1'b1, 32'h0000_0104, 32'h0000_0000); `CHK(ee, 1'b1)
    rd(OFS_OUTPUT_LATCH); `CHK(rr, 32'h0000_00A5)
    $display("test readback done");
    // Capture, trigger and receive paths follow the synchronised pins
    wr(OFS_DIRECTION_BITS, 0); wr(OFS_PIN_ROUTE_CTRL, 3); wr(OFS_TIMER_CFG, 32'h0000_0880);
    wr(OFS_PERIPH_EN, 3); ext_en <= 8'hFF; ext_lvl <= 8'hC2;
    repeat (5) @(posedge pclk);
    `CHK(cap_a, 1'b1)
    `CHK(cap_b, 1'b1)
    `CHK(trig, 1'b1)
    ext_lvl <= 8'h00;
    repeat (5) @(posedge pclk);
    `CHK({cap_a, cap_b, trig}, 3'h0)
    wr(OFS_PERIPH_EN, 32'h0000_0010);
    repeat (2) @(posedge pclk);
    `CHK(rx0, 1'b0)
    wr(OFS_PERIPH_EN, 32'h0000_0240);
    repeat (2) @(posedge pclk);
    `CHK({rx1, sda1, sda0}, 3'h5)
    $display("test inputs done");
    // Mid-run reset returns every pin to input and clears the latch
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK(pin_oe_n, 8'hFF)
    `CHK({pin_out, cap_a, rx0}, 10'h001)
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_OUTPUT_LATCH); `CHK(rr, 32'h0000_0000)
    $display("test reset again done");
    close_out();
  end
endmodule
`default_nettype wire
